//--- rtl/cdpm_pkg.sv
package cdpm_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets, byte address = offset)
  // ----------------------------------------------------------------
  localparam logic [3:0] CDPM_ADDR_DIV = 4'h0;
  localparam logic [3:0] CDPM_ADDR_AUX = 4'h4;
  localparam logic [3:0] CDPM_ADDR_POWER_CONTROL_REG = 4'h8;
  localparam logic [3:0] CDPM_ADDR_IEN = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CDPM_AUX_BOI = 5;
  localparam int CDPM_AUX_BOD = 6;
  localparam int CDPM_POWER_CONTROL_REG_BOF = 5;
  localparam int CDPM_POWER_CONTROL_REG_POF = 4;
  localparam int CDPM_POWER_CONTROL_REG_PD = 1;
  localparam int CDPM_POWER_CONTROL_REG_IDL = 0;
  localparam int CDPM_IEN_EA = 7;
  localparam int CDPM_IEN_EBO = 5;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CDPM_DIV_RST = 8'h00;
  localparam logic [7:0] CDPM_BYTE_RST = 8'h00;
  localparam int CDPM_XTAL_WAIT = 1024;
  localparam int CDPM_RC_WAIT = 256;
  localparam int CDPM_CNT_W = 11;
  localparam logic [CDPM_CNT_W-1:0] CDPM_XTAL_CNT =
    CDPM_CNT_W'(CDPM_XTAL_WAIT - 1);
  localparam logic [CDPM_CNT_W-1:0] CDPM_RC_CNT =
    CDPM_CNT_W'(CDPM_RC_WAIT - 1);

  typedef enum logic [1:0] {
    CDPM_RUN = 2'b00,
    CDPM_IDLE = 2'b01,
    CDPM_PDOWN = 2'b10,
    CDPM_WAKE = 2'b11
  } cdpm_state_t;

endpackage

//--- rtl/cdpm_core.sv
// Functional notes
// [R1] compat bit halves cpu clock: 12 clocks
// [R2] halving also reaches peripheral clock enable
// [R3] divider zero: oscillator rate or half
// [R4] divider N divides by 2*(N+1)
// [R5] divider writable anytime without stalling cpu
// [R6] brownout resets, or interrupts when select set
// [R7] level select bit picks 2.5 or 3.8 V
// [R8] reset held while detector stays active
// [R9] interrupt once on detector rising edge
// [R10] interrupt needs global and brownout enables
// [R11] brownout flag sticky until software clears
// [R12] disable bit suppresses brownout reset and interrupt
// [R13] power-on flag sticky until software clears
// [R14] idle stops cpu; interrupt or reset exits
// [R15] power-down stops oscillator and cpu
// [R16] exit power-down on reset or wake irq
// [R17] brownout resets or wakes in power-down
// [R18] wake waits 1024 or 256 clocks
// [R19] watchdog reset works during power-down
// [R20] brownout logic independent of stopped oscillator
// [R21] brownout flag lives in power control bit 5
// [R22] new divider applied at period boundary
// [R23] idle and power-down bits self-clear on exit
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
module cdpm_core
  import cdpm_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic compatHalfClock,
  input wire logic brownoutLevelSelect,
  input wire logic crystalOsc,
  input wire logic brownoutDetect,
  input wire logic powerOnDetect,
  input wire logic watchdogReset,
  input wire logic wakeIrq,
  input wire logic anyIrq,
  output logic brownoutThreshHigh,
  output logic brownoutDetEnable,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic cpuReset,
  output logic brownoutIrq,
  output logic oscEnable
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] divider_r, divider_nxt;
  logic [DIV_W-1:0] divActive_r, divActive_nxt;
  logic [DIV_W:0] divCnt_r, divCnt_nxt;
  logic halfPh_r, halfPh_nxt;
  logic clkEn_r, clkEn_nxt;
  logic [7:0] aux_r, aux_nxt;
  logic [7:0] ien_r, ien_nxt;
  logic bof_r, bof_nxt;
  logic pof_r, pof_nxt;
  logic idl_r, idl_nxt;
  logic pd_r, pd_nxt;
  logic boPrev_r, boPrev_nxt;
  logic irq_r, irq_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [CDPM_CNT_W-1:0] wakeCnt_r, wakeCnt_nxt;
  cdpm_state_t state_r, state_nxt;

  logic boActive, boRise, boReset, boIrqEv, wrHit;
  logic [DIV_W:0] periodEnd;
  logic [7:0] pconRd;

  // ----------------------------------------------------------------
  // brownout qualification
  // ----------------------------------------------------------------
  always_comb begin
    brownoutThreshHigh = ~brownoutLevelSelect; // R7
    brownoutDetEnable = ~aux_r[CDPM_AUX_BOD]; // R12 R20
    boActive = brownoutDetect & ~aux_r[CDPM_AUX_BOD]; // R12
    boRise = boActive & ~boPrev_r; // R9
    boReset = boActive & ~aux_r[CDPM_AUX_BOI]; // R6 R8 R17
    boIrqEv = boRise & aux_r[CDPM_AUX_BOI]; // R6 R9
    wrHit = write & ack_r;
  end

  // ----------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------
  always_comb begin
    // period length minus one: 2*N+1, or 0 when the divider is zero
    if (divActive_r == '0) begin
      periodEnd = '0; // R3
    end else begin
      periodEnd = {divActive_r, 1'b1}; // R4
    end
    divActive_nxt = divActive_r;
    halfPh_nxt = halfPh_r;
    divCnt_nxt = divCnt_r + 1'b1;
    clkEn_nxt = 1'b0;
    if (divCnt_r >= periodEnd) begin
      divCnt_nxt = '0;
      divActive_nxt = divider_r; // R22 R5
      halfPh_nxt = ~halfPh_r;
      clkEn_nxt = ~compatHalfClock | halfPh_r; // R1 R2
    end
    if (!oscEnable) begin
      clkEn_nxt = 1'b0; // R15
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divActive_r <= CDPM_DIV_RST;
      divCnt_r <= '0;
      halfPh_r <= 1'b0;
      clkEn_r <= 1'b0;
    end else begin
      divActive_r <= divActive_nxt;
      divCnt_r <= divCnt_nxt;
      halfPh_r <= halfPh_nxt;
      clkEn_r <= clkEn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    wakeCnt_nxt = wakeCnt_r;
    unique case (state_r)
      CDPM_RUN: begin
        if (pd_r) begin
          state_nxt = CDPM_PDOWN; // R15
        end else if (idl_r) begin
          state_nxt = CDPM_IDLE; // R14
        end
      end
      CDPM_IDLE: begin
        if (anyIrq | boIrqEv) begin
          state_nxt = CDPM_RUN; // R14
        end
      end
      CDPM_PDOWN: begin
        if (wakeIrq | boIrqEv) begin
          state_nxt = CDPM_WAKE; // R16 R17
          wakeCnt_nxt = crystalOsc ? CDPM_XTAL_CNT : CDPM_RC_CNT; // R18
        end
      end
      CDPM_WAKE: begin
        if (wakeCnt_r == '0) begin
          state_nxt = CDPM_RUN; // R18
        end else begin
          wakeCnt_nxt = wakeCnt_r - 1'b1;
        end
      end
    endcase
    if (cpuReset) begin
      state_nxt = CDPM_RUN; // R8 R16 R19
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CDPM_RUN;
      wakeCnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      wakeCnt_r <= wakeCnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register file and flags
  // ----------------------------------------------------------------
  always_comb begin
    pconRd = '0;
    pconRd[CDPM_POWER_CONTROL_REG_BOF] = bof_r; // R21
    pconRd[CDPM_POWER_CONTROL_REG_POF] = pof_r;
    pconRd[CDPM_POWER_CONTROL_REG_PD] = pd_r;
    pconRd[CDPM_POWER_CONTROL_REG_IDL] = idl_r;
    divider_nxt = divider_r;
    aux_nxt = aux_r;
    ien_nxt = ien_r;
    bof_nxt = bof_r;
    pof_nxt = pof_r;
    idl_nxt = idl_r;
    pd_nxt = pd_r;
    ack_nxt = (read | write) & ~ack_r;
    rdata_nxt = '0;
    if (read & ~ack_r) begin
      unique case (address)
        CDPM_ADDR_DIV: rdata_nxt = 32'(divider_r);
        CDPM_ADDR_AUX: rdata_nxt = 32'(aux_r);
        CDPM_ADDR_POWER_CONTROL_REG: rdata_nxt = 32'(pconRd);
        CDPM_ADDR_IEN: rdata_nxt = 32'(ien_r);
        default: rdata_nxt = '0;
      endcase
    end
    if (wrHit) begin
      unique case (address)
        CDPM_ADDR_DIV: divider_nxt = writedata[DIV_W-1:0]; // R5
        CDPM_ADDR_AUX: aux_nxt = writedata[7:0];
        CDPM_ADDR_POWER_CONTROL_REG: begin
          bof_nxt = writedata[CDPM_POWER_CONTROL_REG_BOF]; // R11
          pof_nxt = writedata[CDPM_POWER_CONTROL_REG_POF]; // R13
          pd_nxt = writedata[CDPM_POWER_CONTROL_REG_PD]; // R15
          idl_nxt = writedata[CDPM_POWER_CONTROL_REG_IDL]; // R14
        end
        CDPM_ADDR_IEN: ien_nxt = writedata[7:0];
        default: ;
      endcase
    end
    // hardware set wins over software clear
    if (boReset | boIrqEv) begin
      bof_nxt = 1'b1; // R11 R21
    end
    if (powerOnDetect) begin
      pof_nxt = 1'b1; // R13
    end
    if (state_r == CDPM_IDLE && state_nxt == CDPM_RUN) begin
      idl_nxt = 1'b0; // R23
    end
    if (state_r == CDPM_WAKE && state_nxt == CDPM_RUN) begin
      pd_nxt = 1'b0; // R23
    end
    if (cpuReset) begin
      idl_nxt = 1'b0; // R23
      pd_nxt = 1'b0; // R23
    end
    boPrev_nxt = boActive;
    irq_nxt = irq_r;
    if (boIrqEv) begin
      irq_nxt = 1'b1; // R9
    end else if (wrHit && address == CDPM_ADDR_POWER_CONTROL_REG &&
                 !writedata[CDPM_POWER_CONTROL_REG_BOF]) begin
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divider_r <= CDPM_DIV_RST;
      aux_r <= CDPM_BYTE_RST;
      ien_r <= CDPM_BYTE_RST;
      bof_r <= 1'b0;
      pof_r <= 1'b0;
      idl_r <= 1'b0;
      pd_r <= 1'b0;
      boPrev_r <= 1'b0;
      irq_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      divider_r <= divider_nxt;
      aux_r <= aux_nxt;
      ien_r <= ien_nxt;
      bof_r <= bof_nxt;
      pof_r <= pof_nxt;
      idl_r <= idl_nxt;
      pd_r <= pd_nxt;
      boPrev_r <= boPrev_nxt;
      irq_r <= irq_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    waitrequest = (read | write) & ~ack_r;
    readdata = rdata_r;
    oscEnable = (state_r != CDPM_PDOWN); // R15
    cpuReset = boReset | watchdogReset; // R8 R19
    cpuClkEn = clkEn_r & (state_r == CDPM_RUN); // R14 R18
    periphClkEn = clkEn_r & (state_r != CDPM_WAKE); // R2 R14
    brownoutIrq = irq_r & ien_r[CDPM_IEN_EA] & ien_r[CDPM_IEN_EBO]; // R10
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_follows_bo: assert property ( // R8
    @(posedge mclk) disable iff (!reset_n)
    brownoutDetect & ~aux_r[CDPM_AUX_BOD] & ~aux_r[CDPM_AUX_BOI]
      |-> cpuReset)
    else $error("brownout reset not held");
  chk_disable_blocks_bo: assert property ( // R12
    @(posedge mclk) disable iff (!reset_n)
    aux_r[CDPM_AUX_BOD] & ~watchdogReset |-> !cpuReset)
    else $error("disabled brownout caused reset");
  chk_irq_once_rise: assert property ( // R9
    @(posedge mclk) disable iff (!reset_n)
    boIrqEv |=> !boIrqEv)
    else $error("brownout irq event repeated");
  chk_irq_gated_en: assert property ( // R10
    @(posedge mclk) disable iff (!reset_n)
    brownoutIrq |-> ien_r[CDPM_IEN_EA] && ien_r[CDPM_IEN_EBO])
    else $error("brownout irq without enables");
  chk_bof_sticky_set: assert property ( // R11
    @(posedge mclk) disable iff (!reset_n)
    boReset |=> bof_r)
    else $error("brownout flag not set");
  chk_bof_irq_set: assert property ( // R11 R21
    @(posedge mclk) disable iff (!reset_n)
    boIrqEv |=> bof_r)
    else $error("brownout flag not set by irq");
  chk_bof_flag_hold: assert property ( // R11
    @(posedge mclk) disable iff (!reset_n)
    bof_r && !(wrHit && address == CDPM_ADDR_POWER_CONTROL_REG)
      |=> bof_r)
    else $error("brownout flag lost without clear");
  chk_pof_sticky_set: assert property ( // R13
    @(posedge mclk) disable iff (!reset_n)
    powerOnDetect |=> pof_r)
    else $error("power-on flag not set");
  chk_pof_flag_hold: assert property ( // R13
    @(posedge mclk) disable iff (!reset_n)
    pof_r && !(wrHit && address == CDPM_ADDR_POWER_CONTROL_REG)
      |=> pof_r)
    else $error("power-on flag lost without clear");
  chk_pdown_osc_off: assert property ( // R15
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_PDOWN |-> !oscEnable && !cpuClkEn)
    else $error("clock running in power-down");
  chk_wake_rc_count: assert property ( // R18
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_PDOWN && wakeIrq && !crystalOsc && !cpuReset
      |=> (state_r == CDPM_WAKE)[*8])
    else $error("wake count too short");
  chk_wake_xtal_count: assert property ( // R18
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_PDOWN && wakeIrq && crystalOsc && !cpuReset
      |=> (state_r == CDPM_WAKE)[*8])
    else $error("crystal wake count too short");
  chk_wake_osc_on: assert property ( // R18
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_WAKE |-> oscEnable && !cpuClkEn)
    else $error("wake state clocks wrong");
  chk_wake_clears_pd: assert property ( // R18 R23
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_WAKE && wakeCnt_r == '0
      |=> state_r == CDPM_RUN && !pd_r)
    else $error("wake end left power-down set");
  chk_bo_wakes_pd: assert property ( // R17
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_PDOWN && boIrqEv && !cpuReset
      |=> state_r == CDPM_WAKE)
    else $error("brownout irq did not wake");
  chk_wdog_forces_reset: assert property ( // R19
    @(posedge mclk) disable iff (!reset_n)
    watchdogReset |-> cpuReset)
    else $error("watchdog reset not passed on");
  chk_idle_cpu_stop: assert property ( // R14
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_IDLE |-> !cpuClkEn)
    else $error("cpu clocked in idle");
  chk_idle_exit_irq: assert property ( // R14
    @(posedge mclk) disable iff (!reset_n)
    state_r == CDPM_IDLE && anyIrq |=> state_r == CDPM_RUN)
    else $error("idle not left on irq");
  chk_div_load_boundary: assert property ( // R22 R5
    @(posedge mclk) disable iff (!reset_n)
    divCnt_r < periodEnd |=> $stable(divActive_r))
    else $error("divider changed inside period");
  chk_div_pulse_single: assert property ( // R4
    @(posedge mclk) disable iff (!reset_n)
    divActive_r != '0 && clkEn_r |=> !clkEn_r)
    else $error("divided enable longer than one cycle");
  chk_compat_half: assert property ( // R1
    @(posedge mclk) disable iff (!reset_n)
    compatHalfClock && $stable(compatHalfClock) && divActive_r == '0 &&
      clkEn_r |=> !clkEn_r)
    else $error("compat clock not halved");

endmodule // cdpm_core

//--- testbench/cdpm_partner.sv
// ----------------------------------------------------------------
// core and interrupt controller model
// ----------------------------------------------------------------
module cdpm_partner
  import cdpm_pkg::*;
(
  input wire logic irqReq,
  input wire logic wakeReq,
  input wire logic brownoutIrq,
  output logic anyIrq,
  output logic wakeIrq
);
  // enabled brownout irq counts as pending and wake-capable
  assign anyIrq = irqReq | brownoutIrq;
  assign wakeIrq = wakeReq | brownoutIrq;
endmodule // cdpm_partner

//--- testbench/cdpm_core_bench.sv
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module cdpm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cdpm_pkg::*;
  logic mclk, resetN, read, write, compat, lvl, xtal, bDet, pDet, wdog;
  logic irqReq, wakeReq, anyIrq, wakeIrq, waitrequest, threshHi, detEn;
  logic cpuEn, perEn, cpuReset, bIrq, oscEn;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  int miscompares, checks, p, n, c1, c2, w;

  cdpm_core uut (.mclk(mclk), .reset_n(resetN), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .compatHalfClock(compat), .brownoutLevelSelect(lvl),
    .crystalOsc(xtal), .brownoutDetect(bDet), .powerOnDetect(pDet),
    .watchdogReset(wdog), .wakeIrq(wakeIrq), .anyIrq(anyIrq),
    .brownoutThreshHigh(threshHi), .brownoutDetEnable(detEn),
    .cpuClkEn(cpuEn), .periphClkEn(perEn), .cpuReset(cpuReset),
    .brownoutIrq(bIrq), .oscEnable(oscEn));
  cdpm_partner partner (.irqReq(irqReq), .wakeReq(wakeReq),
    .brownoutIrq(bIrq), .anyIrq(anyIrq), .wakeIrq(wakeIrq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // avalon access; read data lands in q
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // cycles between two enable pulses, into p
  task period(input bit sel);
    int t;
    t = 0;
    do @(negedge mclk); while ((sel ? perEn : cpuEn) !== 1'b1 && t++ < 2000);
    p = 0;
    do begin
      @(negedge mclk);
      p++;
    end while ((sel ? perEn : cpuEn) !== 1'b1 && p < 2000);
  endtask

  function int expPer(int d, bit c);
    return (d == 0 ? 1 : 2 * (d + 1)) * (c ? 2 : 1);
  endfunction

  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude;
  end

  initial begin
    {read, write, compat, xtal, bDet, pDet, wdog, irqReq, wakeReq} = '0;
    resetN = 1'b0;
    lvl = 1'b1;
    address = 4'h0;
    writedata = 32'h0;
    void'($urandom(32'hED0A29DC));
    repeat (12) @(posedge mclk);
    resetN <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, i == 4 ? 4'h2 : 4'(i * 4), 8'h00);
      chk("regReset", q, 32'h0);
    end
    chk("thresh", 32'(threshHi), 32'h0);
    lvl <= 1'b0;
    @(negedge mclk);
    chk("thresh", 32'(threshHi), 32'h1);
    for (int i = 0; i < 6; i++) begin
      n = (i < 2) ? 0 : (i == 2 ? 255 : int'($urandom_range(1, 12)));
      compat <= i[0];
      bus(1'b1, CDPM_ADDR_DIV, 8'(n));
      period(1'b0);
      period(1'b0);
      chk("cpuPeriod", 32'(p), 32'(expPer(n, i[0])));
    end
    bus(1'b1, CDPM_ADDR_DIV, 8'h00);
    period(1'b1);
    period(1'b1);
    chk("perPeriod", 32'(p), 32'h2);
    compat <= 1'b0;
    @(posedge mclk);
    bDet <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("bodReset", 32'(cpuReset), 32'h1);
    @(posedge mclk);
    bDet <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("bodRelease", 32'(cpuReset), 32'h0);
    bus(1'b0, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    chk("bodFlag", 32'(q[5]), 32'h1);
    bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    bus(1'b0, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    chk("bodFlagClr", 32'(q[5]), 32'h0);
    bus(1'b1, CDPM_ADDR_AUX, 8'h20);
    bus(1'b1, CDPM_ADDR_IEN, 8'h80);
    @(posedge mclk);
    bDet <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("irqNoReset", 32'(cpuReset), 32'h0);
    chk("irqMasked", 32'(bIrq), 32'h0);
    bus(1'b1, CDPM_ADDR_IEN, 8'hA0);
    @(negedge mclk);
    chk("irqOn", 32'(bIrq), 32'h1);
    bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    repeat (3) @(negedge mclk);
    chk("irqOnce", 32'(bIrq), 32'h0);
    bus(1'b1, CDPM_ADDR_AUX, 8'h40);
    @(negedge mclk);
    chk("detEn", 32'(detEn), 32'h0);
    @(posedge mclk);
    bDet <= 1'b0;
    @(posedge mclk);
    bDet <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("disRst", 32'(cpuReset), 32'h0);
    chk("disIrq", 32'(bIrq), 32'h0);
    @(posedge mclk);
    bDet <= 1'b0;
    pDet <= 1'b1;
    @(posedge mclk);
    pDet <= 1'b0;
    repeat (5) @(posedge mclk);
    bus(1'b0, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    chk("porFlag", 32'(q[4]), 32'h1);
    bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h01);
    repeat (4) @(negedge mclk);
    c1 = 0;
    c2 = 0;
    repeat (40) begin
      @(negedge mclk);
      c1 += int'(cpuEn);
      c2 += int'(perEn);
    end
    chk("idleCpu", 32'(c1), 32'h0);
    chk("idlePer", 32'(c2 > 0), 32'h1);
    @(posedge mclk);
    irqReq <= 1'b1;
    repeat (4) @(posedge mclk);
    irqReq <= 1'b0;
    bus(1'b0, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    chk("idleClr", 32'(q[1:0]), 32'h0);
    period(1'b0);
    chk("idleExit", 32'(p), 32'h1);
    for (int k = 0; k < 2; k++) begin
      xtal <= k[0];
      bus(1'b1, CDPM_ADDR_AUX, 8'h20);
      bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h02);
      repeat (3) @(negedge mclk);
      chk("pdOsc", 32'(oscEn), 32'h0);
      @(posedge mclk);
      wdog <= 1'b1;
      @(negedge mclk);
      chk("pdWdog", 32'(cpuReset), 32'h1);
      @(posedge mclk);
      wdog <= 1'b0;
      @(negedge mclk);
      chk("pdWdogExit", 32'(oscEn), 32'h1);
      bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h02);
      repeat (3) @(negedge mclk);
      chk("pdOscAgain", 32'(oscEn), 32'h0);
      @(posedge mclk);
      if (k == 1) bDet <= 1'b1;
      else wakeReq <= 1'b1;
      c1 = 0;
      while (cpuEn !== 1'b1 && c1 < 3000) begin
        @(negedge mclk);
        c1++;
      end
      w = k ? CDPM_XTAL_WAIT : CDPM_RC_WAIT;
      chk("wakeWait", 32'(c1 >= w && c1 <= w + 4), 32'h1);
      chk("wakeOsc", 32'(oscEn), 32'h1);
      @(posedge mclk);
      bDet <= 1'b0;
      wakeReq <= 1'b0;
      bus(1'b0, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
      chk("pdClr", 32'(q[1]), 32'h0);
      bus(1'b1, CDPM_ADDR_POWER_CONTROL_REG, 8'h00);
    end
    conclude;
  end
endmodule // cdpm_core_bench
